// ---- verilog/cps_consts.vh ----
// Behaviour
// [R1] input-buffer-full flag, top status bit, read-only
// [R2] status bit three reads zero, ignores writes
// [R3] low three bits: pin direction, 1 input
// [R4] low read strobe with select: host read
// [R5] low write strobe with select: host write
// [R6] chip select high makes strobes ignored
// [R7] slave mode turns pins into strobe inputs
// [R8] pin data register: three bits, upper zero
// [R9] port writes act as read then write
// [R10] data read returns pin levels
// [R11] data write updates output latch only
// [R12] input pins copied into latch on modify
// [R13] input-full set at Q4 after next Q2
// [R14] output-full cleared when host read starts
// [R15] second unread host write sets overflow
// [R16] outside slave mode both full flags clear
// [R17] slave select: bit four, resets zero
// [R18] firmware sets pins input before slave mode
`ifndef CPS_CONSTS_VH
`define CPS_CONSTS_VH

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define CPS_IDX_PORT_DATA  12'h009
`define CPS_IDX_DIR_STATUS 12'h089
`define CPS_ADDR_PORT_DATA  12'h024
`define CPS_ADDR_DIR_STATUS 12'h224
`define CPS_ADDR_HOST_BYTE  12'h300
`define CPS_ADDR_BIT_SET    12'h304
`define CPS_ADDR_BIT_CLR    12'h308
`define CPS_ADDR_IRQ_STATUS 12'h30c
`define CPS_ADDR_IRQ_MASK   12'h310

// ----------------------------------------
// direction/status fields and reset
// ----------------------------------------
`define CPS_BIT_IBF  7
`define CPS_BIT_OBF  6
`define CPS_BIT_OVF  5
`define CPS_BIT_MODE 4
`define CPS_DIR_RESET 3'h7
`define CPS_IRQ_WR_DONE 0
`define CPS_IRQ_RD_DONE 1

// ----------------------------------------
// quarter-phase timing
// ----------------------------------------
`define CPS_PHASES 4
`define CPS_Q2 2'h1
`define CPS_Q4 2'h3

`endif

// ---- verilog/cps_port.v ----
`timescale 1ns/1ns
`include "cps_consts.vh"

module cps_port
(
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // control pins
  input  wire [2:0]  ctl_pin_in,
  output reg  [2:0]  ctl_pin_out,
  output reg  [2:0]  ctl_pin_oe,
  // host byte port pins
  input  wire [7:0]  host_data_in,
  output reg  [7:0]  host_data_out,
  output reg         host_data_oe,
  // interrupt
  output reg         irq
);

// ----------------------------------------
// helpers
// ----------------------------------------
function hit;
  input [11:0] a;
  input [11:0] b;
  begin
    hit = (a == b);
  end
endfunction

function [10:0] agree;
  input [10:0] s2;
  input [10:0] s3;
  input [10:0] held;
  begin
    agree = (s2 & s3) | (held & (s2 ^ s3));
  end
endfunction

function rise;
  input now;
  input was;
  begin
    rise = now & ~was;
  end
endfunction

function fall;
  input now;
  input was;
  begin
    fall = ~now & was;
  end
endfunction

function phase_done;
  input       pend;
  input       q2;
  input [1:0] ph;
  begin
    phase_done = pend & q2 & (ph == `CPS_Q4);
  end
endfunction

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// three stages; a change counts once stages two and three agree
// judged bit by bit, so a moving data bus cannot hold back a strobe
reg [10:0] sync1;
reg [10:0] sync2;
reg [10:0] sync3;
reg [10:0] pins;
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    sync1 <= 11'h7ff;
    sync2 <= 11'h7ff;
    sync3 <= 11'h7ff;
    pins  <= 11'h7ff;
  end
  else
  begin
    sync1 <= {host_data_in, ctl_pin_in};
    sync2 <= sync1;
    sync3 <= sync2;
    pins  <= agree(sync2, sync3, pins);
  end
end

wire [2:0] ctl_pins  = pins[2:0];
wire [7:0] host_pins = pins[10:3];

// ----------------------------------------
// registers
// ----------------------------------------
reg  [2:0] pin_latch;
reg  [2:0] dir;
reg        mode;
reg        input_buffer_full;
reg        output_buffer_full;
reg        ovf;
reg  [7:0] in_byte;
reg  [1:0] irq_status;
reg  [1:0] irq_mask;
reg  [1:0] qph;

wire setup  = psel & ~penable;
wire access = psel & penable & pready;
wire wr     = access & pwrite;
wire rd     = access & ~pwrite;

// strobes act only with chip select low and slave mode on
wire host_wr = mode & ~ctl_pins[2] & ~ctl_pins[1]; // see [R5] see [R6] see [R7]
wire host_rd = mode & ~ctl_pins[2] & ~ctl_pins[0]; // see [R4] see [R6] see [R7]
reg  host_wr_d;
reg  host_rd_d;
wire wr_start = rise(host_wr, host_wr_d);
wire wr_end   = fall(host_wr, host_wr_d);
wire rd_start = rise(host_rd, host_rd_d);
wire rd_end   = fall(host_rd, host_rd_d);

// completion waits for a Q2 then lands on the following Q4
reg  wr_pend;
reg  wr_q2;
reg  rd_pend;
reg  rd_q2;
wire wr_done = phase_done(wr_pend, wr_q2, qph); // see [R13]
wire rd_done = phase_done(rd_pend, rd_q2, qph);

wire [7:0] dir_status = {input_buffer_full, output_buffer_full, ovf, mode, 1'b0, dir}; // see [R1] see [R2]

reg [31:0] rd_mux;
always @*
begin
  rd_mux = 32'h0;
  if (hit(paddr, `CPS_ADDR_PORT_DATA))
    rd_mux = {29'h0, ctl_pins}; // see [R8] see [R10]
  else if (hit(paddr, `CPS_ADDR_DIR_STATUS))
    rd_mux = {24'h0, dir_status};
  else if (hit(paddr, `CPS_ADDR_HOST_BYTE))
    rd_mux = {24'h0, in_byte};
  else if (hit(paddr, `CPS_ADDR_IRQ_STATUS))
    rd_mux = {30'h0, irq_status};
  else if (hit(paddr, `CPS_ADDR_IRQ_MASK))
    rd_mux = {30'h0, irq_mask};
end

wire mapped = hit(paddr, `CPS_ADDR_PORT_DATA)
            | hit(paddr, `CPS_ADDR_DIR_STATUS)
            | hit(paddr, `CPS_ADDR_HOST_BYTE)
            | hit(paddr, `CPS_ADDR_BIT_SET)
            | hit(paddr, `CPS_ADDR_BIT_CLR)
            | hit(paddr, `CPS_ADDR_IRQ_STATUS)
            | hit(paddr, `CPS_ADDR_IRQ_MASK);

// ----------------------------------------
// next values
// ----------------------------------------
reg [2:0] next_latch;
always @*
begin
  next_latch = pin_latch;
  if (wr && hit(paddr, `CPS_ADDR_PORT_DATA))
    next_latch = pwdata[2:0]; // see [R11]
  // bit set/clear start from the pin levels, so input pins
  // overwrite their latch bits
  else if (wr && hit(paddr, `CPS_ADDR_BIT_SET))
    next_latch = ctl_pins | pwdata[2:0]; // see [R9] see [R12]
  else if (wr && hit(paddr, `CPS_ADDR_BIT_CLR))
    next_latch = ctl_pins & ~pwdata[2:0]; // see [R9] see [R12]
end

wire in_read   = rd && hit(paddr, `CPS_ADDR_HOST_BYTE);
wire out_write = wr && hit(paddr, `CPS_ADDR_HOST_BYTE);
wire ds_write  = wr && hit(paddr, `CPS_ADDR_DIR_STATUS);
wire irq_clr   = wr && hit(paddr, `CPS_ADDR_IRQ_STATUS);

reg next_ibf;
reg next_obf;
reg next_ovf;
always @*
begin
  // setting wins over the clearing access in the same cycle
  next_ibf = wr_done | (input_buffer_full & ~in_read); // see [R13]
  next_obf = out_write | (output_buffer_full & ~rd_start); // see [R14]
  next_ovf = (wr_start & (input_buffer_full | wr_pend))
           | (ovf & ~(ds_write & ~pwdata[`CPS_BIT_OVF])); // see [R15]
  if (!mode)
  begin
    next_ibf = 1'b0; // see [R16]
    next_obf = 1'b0; // see [R16]
  end
end

wire [1:0] next_irq_status = {rd_done, wr_done}
                           | (irq_status & ~(irq_clr ? pwdata[1:0] : 2'h0));

// ----------------------------------------
// state
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pin_latch  <= 3'h0;
    dir        <= `CPS_DIR_RESET; // see [R3]
    mode       <= 1'b0; // see [R17]
    input_buffer_full        <= 1'b0;
    output_buffer_full        <= 1'b0;
    ovf        <= 1'b0;
    in_byte    <= 8'h00;
    irq_status <= 2'h0;
    irq_mask   <= 2'h0;
    qph        <= 2'h0;
    host_wr_d  <= 1'b0;
    host_rd_d  <= 1'b0;
    wr_pend    <= 1'b0;
    wr_q2      <= 1'b0;
    rd_pend    <= 1'b0;
    rd_q2      <= 1'b0;
  end
  else
  begin
    pin_latch <= next_latch;
    if (ds_write)
    begin
      dir  <= pwdata[2:0]; // see [R3]
      mode <= pwdata[`CPS_BIT_MODE]; // see [R17]
    end
    input_buffer_full        <= next_ibf;
    output_buffer_full        <= next_obf;
    ovf        <= next_ovf;
    irq_status <= next_irq_status;
    if (wr && hit(paddr, `CPS_ADDR_IRQ_MASK))
      irq_mask <= pwdata[1:0];
    qph       <= qph + 2'h1;
    host_wr_d <= host_wr;
    host_rd_d <= host_rd;
    // the byte stays current while the host holds the strobe
    if (host_wr)
      in_byte <= host_pins;
    if (wr_end)
    begin
      wr_pend <= 1'b1;
      wr_q2   <= 1'b0;
    end
    else if (wr_done)
      wr_pend <= 1'b0;
    else if (wr_pend && qph == `CPS_Q2)
      wr_q2 <= 1'b1;
    if (rd_end)
    begin
      rd_pend <= 1'b1;
      rd_q2   <= 1'b0;
    end
    else if (rd_done)
      rd_pend <= 1'b0;
    else if (rd_pend && qph == `CPS_Q2)
      rd_q2 <= 1'b1;
  end
end

// ----------------------------------------
// outputs
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    prdata        <= 32'h0;
    pready        <= 1'b0;
    pslverr       <= 1'b0;
    ctl_pin_out   <= 3'h0;
    ctl_pin_oe    <= 3'h0;
    host_data_out <= 8'h00;
    host_data_oe  <= 1'b0;
    irq           <= 1'b0;
  end
  else
  begin
    // one wait-free access phase after every setup cycle
    pready  <= setup;
    pslverr <= setup & ~mapped;
    if (setup && !pwrite)
      prdata <= rd_mux;
    ctl_pin_out <= next_latch;
    // pins never drive in slave mode, whatever firmware left
    ctl_pin_oe <= ~dir & {3{~mode}}; // see [R7] see [R18]
    if (out_write)
      host_data_out <= pwdata[7:0];
    host_data_oe <= host_rd;
    irq <= |(next_irq_status & irq_mask);
  end
end

endmodule

// ---- dv/cps_host_model.sv ----
`timescale 1ns/1ns
module cps_host_model
(
  // clock
  input  wire       pclk,
  // control pins
  input  wire [2:0] ctl_pin_out,
  input  wire [2:0] ctl_pin_oe,
  output wire [2:0] ctl_pin_in,
  // byte bus
  input  wire [7:0] host_data_out,
  input  wire       host_data_oe,
  output wire [7:0] host_data_in
);
  // ----
  // host side
  // ----
  reg [2:0] ext = 3'h7;
  reg [7:0] drv = 8'ha5;
  assign ctl_pin_in = ctl_pin_oe & ctl_pin_out | ~ctl_pin_oe & ext;
  assign host_data_in = host_data_oe ? host_data_out : drv;
  // data outlives the strobe, the pin filter lags it
  task xfer(input [2:0] e, input [7:0] b, input integer n,
            output [7:0] got);
  begin
    ext <= e;
    drv <= b;
    repeat (n) @(posedge pclk);
    got = host_data_in;
    ext <= 3'h7;
    repeat (6) @(posedge pclk);
    drv <= ~b;
    repeat (8) @(posedge pclk);
  end
  endtask
endmodule

// ---- dv/cps_port_asserts.sv ----
`timescale 1ns/1ns
`include "cps_consts.vh"
module cps_port_asserts
(
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // pins
  input wire [2:0]  ctl_pin_in,
  input wire [2:0]  ctl_pin_out,
  input wire [2:0]  ctl_pin_oe,
  input wire        host_data_oe
);
  // ----
  // checks
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire      acc = psel && penable && pready;
  wire      dir = paddr == `CPS_ADDR_DIR_STATUS;
  wire      dat = paddr == `CPS_ADDR_PORT_DATA;
  reg [2:0] dir_w;
  always @(posedge pclk)
    if (acc && pwrite && dir)
      dir_w <= pwdata[2:0];
  bit3_zero_a: assert property (
    acc && !pwrite && dir |-> !prdata[3]) else $error("bit three set");
  data_upper_a: assert property (
    acc && !pwrite && dat |-> prdata[31:3] == 0) else $error("upper set");
  latch_write_a: assert property (
    acc && pwrite && dat |=> ctl_pin_out == $past(pwdata[2:0]))
    else $error("latch not written");
  dir_drive_a: assert property (
    acc && pwrite && dir && !pwdata[4] |-> ##2 ctl_pin_oe == ~dir_w)
    else $error("direction wrong");
  slave_float_a: assert property (
    acc && pwrite && dir && pwdata[4] |-> ##2 ctl_pin_oe == 3'h0)
    else $error("pins driven");
  host_oe_a: assert property (
    host_data_oe |-> ctl_pin_oe == 3'h0) else $error("pins driven in read");
  cs_idle_a: assert property (
    ctl_pin_in[2] [*6] |-> !host_data_oe) else $error("read unselected");
  rd_idle_a: assert property (
    ctl_pin_in[0] [*6] |-> !host_data_oe) else $error("read without strobe");
  cover property (host_data_oe);
  cover property (acc && pwrite && dir && pwdata[4]);
  cover property (acc && pwrite && paddr == `CPS_ADDR_BIT_SET);
endmodule
bind cps_port cps_port_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .paddr, .pwdata, .prdata, .ctl_pin_in, .ctl_pin_out, .ctl_pin_oe,
  .host_data_oe);

// ---- dv/ctl_port_slave_status_tb.sv ----
`timescale 1ns/1ns
`include "cps_consts.vh"
module ctl_port_slave_status_tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [2:0]  ctl_pin_in;
  wire [2:0]  ctl_pin_out;
  wire [2:0]  ctl_pin_oe;
  wire [7:0]  host_data_in;
  wire [7:0]  host_data_out;
  wire        host_data_oe;
  wire        irq;
  integer     n_mismatch = 0;
  integer     cmp_count = 0;
  reg  [31:0] r;
  reg  [31:0] st;
  reg         err;
  reg  [7:0]  b0;
  reg  [7:0]  b1;
  reg  [7:0]  g;
  reg  [2:0]  v;
  always #25 pclk = ~pclk;
  cps_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ctl_pin_in, .ctl_pin_out, .ctl_pin_oe,
    .host_data_in, .host_data_out, .host_data_oe, .irq);
  cps_host_model host (.pclk, .ctl_pin_out, .ctl_pin_oe, .ctl_pin_in,
    .host_data_out, .host_data_oe, .host_data_in);
  // ----
  // tasks
  // ----
  task chk(input [63:0] what, input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error %0s: expected %h, seen %h", what, exp, seen);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task rd(input [11:0] a, input [31:0] e);
  begin
    apb(0, a, 0);
    chk("rdata", r, e);
  end
  endtask
  task sts;
    rd(`CPS_ADDR_DIR_STATUS, st);
  endtask
  task give_verdict;
  begin
    $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // ----
  // tests
  // ----
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
  initial
  begin
    void'($urandom(13449));
    v = $urandom;
    b0 = $urandom;
    b1 = $urandom;
    st = 32'h07;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    sts;
    rd(12'h0f0, 0);
    chk("slverr", err, 1);
    apb(1, `CPS_ADDR_DIR_STATUS, 32'hff);
    st = 32'h17;
    sts;
    $display("test 1 done");
    apb(1, `CPS_ADDR_DIR_STATUS, 0);
    apb(1, `CPS_ADDR_PORT_DATA, v);
    repeat (6) @(posedge pclk);
    rd(`CPS_ADDR_PORT_DATA, v);
    host.ext <= ~v;
    apb(1, `CPS_ADDR_DIR_STATUS, 3);
    repeat (6) @(posedge pclk);
    rd(`CPS_ADDR_PORT_DATA, {v[2], ~v[1:0]});
    apb(1, `CPS_ADDR_BIT_SET, 4);
    apb(1, `CPS_ADDR_DIR_STATUS, 0);
    host.ext <= 3'h7;
    repeat (6) @(posedge pclk);
    rd(`CPS_ADDR_PORT_DATA, {1'b1, ~v[1:0]});
    $display("test 2 done");
    apb(1, `CPS_ADDR_DIR_STATUS, 32'h17);
    host.xfer(3'h1, b0, 8, g);
    chk("irq", irq, 0);
    apb(1, `CPS_ADDR_IRQ_MASK, 3);
    st[7] = 1'b1;
    sts;
    chk("irq", irq, 1);
    host.xfer(3'h1, b1, 4, g);
    st[5] = 1'b1;
    sts;
    rd(`CPS_ADDR_HOST_BYTE, b1);
    st[7] = 1'b0;
    sts;
    apb(1, `CPS_ADDR_HOST_BYTE, b0);
    st[6] = 1'b1;
    sts;
    host.xfer(3'h2, ~b0, 8, g);
    chk("hostbyte", g, b0);
    st[6] = 1'b0;
    sts;
    apb(1, `CPS_ADDR_IRQ_STATUS, 3);
    rd(`CPS_ADDR_IRQ_STATUS, 0);
    chk("irq", irq, 0);
    host.xfer(3'h5, b0, 8, g);
    sts;
    host.xfer(3'h1, b0, 8, g);
    apb(1, `CPS_ADDR_DIR_STATUS, 32'h27);
    st[4] = 1'b0;
    sts;
    $display("test 3 done");
    give_verdict;
  end
endmodule
